// ### include/dma_status_consts.svh
// Register offsets, field positions, reset values and the status mask for one channel.
// Included by the channel design file and by the testbench.
`ifndef DMA_STATUS_CONSTS_SVH
`define DMA_STATUS_CONSTS_SVH
`define OFS_CONTROL      12'h000
`define OFS_STATUS       12'h004
`define OFS_CUR_ADDR_A   12'h008
`define OFS_CUR_ADDR_B   12'h00c
`define OFS_CUR_COUNT    12'h010
`define OFS_RLD_ADDR_A   12'h014
`define OFS_RLD_ADDR_B   12'h018
`define OFS_RLD_COUNT    12'h01c
`define OFS_IRQ_STATUS   12'h020
`define OFS_IRQ_MASK     12'h024
`define BIT_TC           0
`define BIT_OVR          1
`define BIT_CHANNEL_ACTIVE_FLAG         2
`define BIT_VLD          3
`define CTL_ENABLE       0
`define CTL_BUF_MODE     1
`define CTL_DOUBLE       2
`define CTL_TWO_ADDR     3
`define CTL_CYCLE_SIZE   4
`define CTL_UPD_A        9
`define CTL_STEP_A_LO    10
`define CTL_UPD_B        12
`define CTL_STEP_B_LO    13
`define CONTROL_RESET    32'h0000_0000
`define STATUS_RESET     4'h0
`define STATUS_USED_MASK 8'h0f
`endif

// ### include/dma_status_pkg.sv
// Types shared by the channel status and reload logic.
// Assumes the constants header is on the include path.
package dma_status_pkg;
    // Field view of the channel control register.
    typedef struct packed {
        logic       enable;
        logic       buf_mode;
        logic       double_buf;
        logic       two_addr;
        logic       cycle_word;
        logic       upd_a;
        logic [1:0] step_a;
        logic       upd_b;
        logic [1:0] step_b;
    } ctl_fields_t;
    // Sticky event flags of one channel.
    typedef struct packed {
        logic vld;
        logic channel_overrun_flag;
        logic tc;
    } flags_t;
endpackage

// ### rtl/addr_step.sv
// Next-address computation for one device address of a channel.
// Assumes the caller only applies the result when a transfer beat occurs.
`timescale 1ns/10ps
`default_nettype none
module addr_step #(
    parameter int AW = 24
) (
    input  wire logic [AW-1:0] addr_i,
    input  wire logic          update_i,
    input  wire logic [1:0]    step_i,
    input  wire logic          word_i,
    output logic      [AW-1:0] addr_o
);
    logic [AW-1:0] delta;
    // Step coding: 00 +1, 01 +2, 10 -1, 11 -2; word cycles always step by two.
    always_comb begin
        delta = step_i[0] ? AW'(2) : AW'(1);
        if (word_i) begin
            delta = AW'(2);
        end
        if (!update_i) begin
            addr_o = addr_i;
        end else if (step_i[1]) begin
            addr_o = addr_i - delta;
        end else begin
            addr_o = addr_i + delta;
        end
    end
endmodule
`default_nettype wire

// ### rtl/dma_channel_status_reload.sv
// Status flags, working counters and block reload for one DMA channel.
// Assumes an APB master on ref_clk_i and a mover that pulses beat_i once
// per bus cycle it completes while channel_active_o is high.
//
// Notes on behaviour
// - Terminal count flag sets when the block count reaches zero.
// - Double-buffer: overrun when a block ends without valid next parameters.
// - Auto-initialize: overrun when a block ends with terminal count still set.
// - Single-buffer mode leaves the overrun flag untouched.
// - Active flag is enable and count above zero; read only.
// - Any write to reload count sets the valid flag.
// - Reload-mode block end clears valid; copies reload count and address A, and address B in two-address mode, to working ones if valid or auto-init.
// - Terminal count and overrun clear only by writing one to their position.
// - Writing the current count starts the channel if already enabled.
// - Cycle size picks byte or word per bus cycle.
// - Reset clears flags; reserved status bits read zero.
// - Address step coding 00 +1, 01 +2, 10 -1, 11 -2.
`timescale 1ns/10ps
`default_nettype none
`include "dma_status_consts.svh"
module dma_channel_status_reload #(
    parameter int AW = 24,
    parameter int CW = 16
) (
    input  wire logic        ref_clk_i,
    input  wire logic        resetn_i,
    input  wire logic        psel_i,
    input  wire logic        penable_i,
    input  wire logic        pwrite_i,
    input  wire logic [11:0] paddr_i,
    input  wire logic [31:0] pwdata_i,
    output logic      [31:0] prdata_o,
    output logic             pready_o,
    output logic             pslverr_o,
    input  wire logic        beat_i,
    output logic             channel_active_o,
    output logic [AW-1:0]    addr_a_o,
    output logic [AW-1:0]    addr_b_o,
    output logic             cycle_word_o,
    output logic             irq_o
);
    import dma_status_pkg::*;

    // All checks below sample on the channel clock and idle in reset.
    default clocking chk_cb @(posedge ref_clk_i);
    endclocking
    default disable iff (!resetn_i);

    logic [31:0]   control_r;
    logic [AW-1:0] cur_a_r;
    logic [AW-1:0] cur_b_r;
    logic [CW-1:0] cur_count_r;
    logic [AW-1:0] rld_a_r;
    logic [AW-1:0] rld_b_r;
    logic [CW-1:0] rld_count_r;
    flags_t        flags_r;
    logic [3:0]    irq_stat_r;
    logic [3:0]    irq_mask_r;
    ctl_fields_t   ctl;
    logic          active;
    logic          block_done;
    logic          acc;
    logic          wr;
    logic [AW-1:0] next_a;
    logic [AW-1:0] next_b;
    logic [31:0]   rd_nxt;
    logic          hit;
    logic          overrun_evt;

    // Decode of the access phase, shared by all register writes.
    function automatic logic wr_to(input logic [11:0] a, input logic [11:0] o);
        return (a == o);
    endfunction

    assign acc = psel_i && penable_i;
    assign wr  = acc && pwrite_i;

    // Control register split into its fields.
    always_comb begin
        ctl.enable     = control_r[`CTL_ENABLE];
        ctl.buf_mode   = control_r[`CTL_BUF_MODE];
        ctl.double_buf = control_r[`CTL_DOUBLE];
        ctl.two_addr   = control_r[`CTL_TWO_ADDR];
        ctl.cycle_word = control_r[`CTL_CYCLE_SIZE];
        ctl.upd_a      = control_r[`CTL_UPD_A];
        ctl.step_a     = control_r[`CTL_STEP_A_LO +: 2];
        ctl.upd_b      = control_r[`CTL_UPD_B];
        ctl.step_b     = control_r[`CTL_STEP_B_LO +: 2];
    end

    // Active while enabled and the count is above zero.
    assign active = ctl.enable && (cur_count_r != '0);
    // A beat on the last unit ends the block.
    assign block_done = active && beat_i && (cur_count_r == CW'(1));
    assign overrun_evt = block_done && ctl.double_buf &&
        (ctl.buf_mode ? flags_r.tc : !flags_r.vld);

    // Address advance per beat, scaled by cycle size.
    addr_step #(.AW(AW)) step_a_u (
        .addr_i   (cur_a_r),
        .update_i (ctl.upd_a),
        .step_i   (ctl.step_a),
        .word_i   (ctl.cycle_word),
        .addr_o   (next_a)
    );
    addr_step #(.AW(AW)) step_b_u (
        .addr_i   (cur_b_r),
        .update_i (ctl.upd_b && ctl.two_addr),
        .step_i   (ctl.step_b),
        .word_i   (ctl.cycle_word),
        .addr_o   (next_b)
    );

    // Control register, written by software only.
    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            control_r <= `CONTROL_RESET;
        end else if (wr && wr_to(paddr_i, `OFS_CONTROL)) begin
            control_r <= pwdata_i;
        end
    end

    // Working counters: software load, per-beat advance and block reload.
    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            cur_a_r     <= '0;
            cur_b_r     <= '0;
            cur_count_r <= '0;
        end else if (block_done) begin
            // Reload in the same cycle the count reaches zero.
            if (ctl.double_buf && (flags_r.vld || ctl.buf_mode)) begin
                cur_a_r     <= rld_a_r;
                cur_b_r     <= ctl.two_addr ? rld_b_r : next_b;
                cur_count_r <= rld_count_r;
            end else begin
                cur_a_r     <= next_a;
                cur_b_r     <= next_b;
                cur_count_r <= '0;
            end
        end else if (active && beat_i) begin
            cur_a_r     <= next_a;
            cur_b_r     <= next_b;
            cur_count_r <= cur_count_r - CW'(1);
        end else if (wr) begin
            if (wr_to(paddr_i, `OFS_CUR_ADDR_A)) begin
                cur_a_r <= pwdata_i[AW-1:0];
            end
            if (wr_to(paddr_i, `OFS_CUR_ADDR_B)) begin
                cur_b_r <= pwdata_i[AW-1:0];
            end
            // A nonzero count with enable set activates at once.
            if (wr_to(paddr_i, `OFS_CUR_COUNT)) begin
                cur_count_r <= pwdata_i[CW-1:0];
            end
        end
    end

    // Reload registers, written by software only.
    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            rld_a_r     <= '0;
            rld_b_r     <= '0;
            rld_count_r <= '0;
        end else if (wr) begin
            if (wr_to(paddr_i, `OFS_RLD_ADDR_A)) begin
                rld_a_r <= pwdata_i[AW-1:0];
            end
            if (wr_to(paddr_i, `OFS_RLD_ADDR_B)) begin
                rld_b_r <= pwdata_i[AW-1:0];
            end
            if (wr_to(paddr_i, `OFS_RLD_COUNT)) begin
                rld_count_r <= pwdata_i[CW-1:0];
            end
        end
    end

    // Sticky flags; a hardware set in the same cycle beats the clear.
    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            flags_r <= '0;
        end else begin
            // Write one to clear each flag alone.
            if (wr && wr_to(paddr_i, `OFS_STATUS)) begin
                if (pwdata_i[`BIT_TC]) flags_r.tc <= 1'b0;
                if (pwdata_i[`BIT_OVR]) flags_r.channel_overrun_flag <= 1'b0;
                if (pwdata_i[`BIT_VLD]) flags_r.vld <= 1'b0;
            end
            // Every block end in a reload mode consumes the parameters.
            if (block_done && ctl.double_buf) begin
                flags_r.vld <= 1'b0;
            end
            // Reload count write validates, wins over clears.
            if (wr && wr_to(paddr_i, `OFS_RLD_COUNT)) begin
                flags_r.vld <= 1'b1;
            end
            // Terminal count set wins over a clear.
            if (block_done) begin
                flags_r.tc <= 1'b1;
            end
            // Overrun set wins over a clear.
            if (overrun_evt) begin
                flags_r.channel_overrun_flag <= 1'b1;
            end
        end
    end

    // Interrupt status: events latch, write one clears, set wins.
    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            irq_stat_r <= '0;
            irq_mask_r <= '0;
        end else begin
            if (wr && wr_to(paddr_i, `OFS_IRQ_MASK)) begin
                irq_mask_r <= pwdata_i[3:0];
            end
            irq_stat_r <= (irq_stat_r &
                ~((wr && wr_to(paddr_i, `OFS_IRQ_STATUS)) ?
                  pwdata_i[3:0] : 4'h0)) |
                {1'b0, 1'b0, overrun_evt, block_done};
        end
    end

    // Read mux; reserved status bits read zero.
    always_comb begin
        hit    = 1'b1;
        rd_nxt = 32'h0000_0000;
        case (paddr_i)
            `OFS_CONTROL:    rd_nxt = control_r;
            `OFS_STATUS:     rd_nxt = {28'h0000000, flags_r.vld, active,
                                       flags_r.channel_overrun_flag, flags_r.tc};
            `OFS_CUR_ADDR_A: rd_nxt = 32'(cur_a_r);
            `OFS_CUR_ADDR_B: rd_nxt = 32'(cur_b_r);
            `OFS_CUR_COUNT:  rd_nxt = 32'(cur_count_r);
            `OFS_RLD_ADDR_A: rd_nxt = 32'(rld_a_r);
            `OFS_RLD_ADDR_B: rd_nxt = 32'(rld_b_r);
            `OFS_RLD_COUNT:  rd_nxt = 32'(rld_count_r);
            `OFS_IRQ_STATUS: rd_nxt = {28'h0000000, irq_stat_r};
            `OFS_IRQ_MASK:   rd_nxt = {28'h0000000, irq_mask_r};
            default:         hit = 1'b0;
        endcase
    end

    // APB answer: no wait state, ready pulses in the first access cycle.
    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            pready_o  <= 1'b0;
            pslverr_o <= 1'b0;
            prdata_o  <= '0;
        end else begin
            pready_o  <= psel_i && !penable_i;
            pslverr_o <= psel_i && !penable_i && !hit;
            prdata_o  <= (psel_i && !penable_i && !pwrite_i) ? rd_nxt : '0;
        end
    end

    // Registered copies of state for the mover and interrupt line.
    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            channel_active_o <= 1'b0;
            addr_a_o         <= '0;
            addr_b_o         <= '0;
            cycle_word_o     <= 1'b0;
            irq_o            <= 1'b0;
        end else begin
            channel_active_o <= active;
            addr_a_o         <= cur_a_r;
            addr_b_o         <= cur_b_r;
            cycle_word_o     <= ctl.cycle_word;
            irq_o            <= |(irq_stat_r & irq_mask_r);
        end
    end

    // Terminal count follows every block end one cycle later.
    chk_tc_on_done: assert property (block_done |=> flags_r.tc)
        else $error("terminal count not set after block end");
    // Double-buffer overrun when a block ends without valid parameters.
    chk_ovr_double: assert property (
        (block_done && ctl.double_buf && !ctl.buf_mode && !flags_r.vld)
        |=> flags_r.channel_overrun_flag)
        else $error("overrun missed in double-buffer mode");
    // Auto-initialize overrun when terminal count is still pending.
    chk_ovr_auto: assert property (
        (block_done && ctl.double_buf && ctl.buf_mode && flags_r.tc)
        |=> flags_r.channel_overrun_flag)
        else $error("overrun missed in auto-initialize mode");
    // Single-buffer operation never raises the overrun flag.
    chk_ovr_single: assert property (
        (!ctl.double_buf && !flags_r.channel_overrun_flag) |=> !flags_r.channel_overrun_flag)
        else $error("overrun changed in single-buffer mode");
    // Active output tracks enable and a nonzero count, one cycle late.
    chk_active_flag: assert property (
        channel_active_o == $past(ctl.enable && (cur_count_r != '0)))
        else $error("active output disagrees with enable and count");
    // A reload count write always validates the next parameters.
    chk_vld_set: assert property (
        (wr && paddr_i == `OFS_RLD_COUNT) |=> flags_r.vld)
        else $error("valid flag not set by reload count write");
    // Double-buffer reload copies the count and consumes the parameters.
    chk_reload_copy: assert property (
        (block_done && ctl.double_buf && !ctl.buf_mode && flags_r.vld &&
         !(wr && paddr_i == `OFS_RLD_COUNT))
        |=> (cur_count_r == $past(rld_count_r)) && !flags_r.vld)
        else $error("reload copy or valid clear missing");
    // Auto-initialize reloads the count and clears valid at every end.
    chk_auto_reload: assert property (
        (block_done && ctl.double_buf && ctl.buf_mode &&
         !(wr && paddr_i == `OFS_RLD_COUNT))
        |=> (cur_count_r == $past(rld_count_r)) && !flags_r.vld)
        else $error("auto-initialize reload or valid clear missing");
    // Terminal count holds until software writes a one to it.
    chk_sticky_tc: assert property (
        (flags_r.tc && !(wr && paddr_i == `OFS_STATUS && pwdata_i[`BIT_TC]))
        |=> flags_r.tc)
        else $error("terminal count dropped without a clear");
    // Overrun holds until software writes a one to it.
    chk_sticky_ovr: assert property (
        (flags_r.channel_overrun_flag &&
         !(wr && paddr_i == `OFS_STATUS && pwdata_i[`BIT_OVR]))
        |=> flags_r.channel_overrun_flag)
        else $error("overrun dropped without a clear");
    // Writing a nonzero count with enable set starts the channel.
    chk_start_write: assert property (
        (wr && paddr_i == `OFS_CUR_COUNT && pwdata_i[CW-1:0] != '0 &&
         ctl.enable && !beat_i && !(wr && paddr_i == `OFS_CONTROL))
        |=> ##1 channel_active_o)
        else $error("count write did not start the channel");
    // A byte step of plus one advances address A by exactly one.
    chk_step_a: assert property (
        (active && beat_i && !block_done && ctl.upd_a && !ctl.cycle_word &&
         ctl.step_a == 2'b00)
        |=> cur_a_r == $past(cur_a_r) + AW'(1))
        else $error("address A byte increment wrong");
    // Status reads return zero in every reserved bit.
    chk_reserved_zero: assert property (
        (psel_i && !penable_i && !pwrite_i && paddr_i == `OFS_STATUS)
        |=> prdata_o[31:4] == 28'h0000000)
        else $error("reserved status bits read nonzero");
endmodule
`default_nettype wire

// ### bench/mover_model.sv
// Behavioural data mover that stands at the far side of one channel.
// Assumes the channel counts beat_o pulses only while it reports active.
`timescale 1ns/10ps
`default_nettype none
module mover_model (
    input  wire logic       ref_clk_i,
    input  wire logic       resetn_i,
    input  wire logic       active_i,
    input  wire logic       run_i,
    input  wire logic [3:0] gap_i,
    output logic            beat_o
);
    logic [3:0] wait_r;

    // One bus cycle per pulse, then an idle gap of gap_i plus one cycles.
    // The gap lets the late active flag settle before the next pulse.
    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            beat_o <= 1'b0;
            wait_r <= 4'h0;
        end else if (beat_o) begin
            beat_o <= 1'b0;
            wait_r <= gap_i;
        end else if (wait_r != 4'h0) begin
            wait_r <= wait_r - 4'h1;
        end else begin
            beat_o <= run_i & active_i;
        end
    end
endmodule
`default_nettype wire

// ### bench/testbench.sv
// Self-checking bench for the channel status and reload logic.
// Assumes the constants header is on the include path.
`timescale 1ns/10ps
`default_nettype none
`include "dma_status_consts.svh"
`define CHECK(nm, exp, got) begin n_tests++; if ((got) !== (exp)) begin \
    fails++; $display("[FAIL] %s expected %h seen %h", nm, exp, got); end end
module testbench;
    import dma_status_pkg::*;
    logic        ref_clk_i;
    logic        resetn_i;
    logic        psel_i;
    logic        penable_i;
    logic        pwrite_i;
    logic [11:0] paddr_i;
    logic [31:0] pwdata_i;
    logic [31:0] prdata_o;
    logic        pready_o;
    logic        pslverr_o;
    logic        beat_i;
    logic        channel_active_o;
    logic [23:0] addr_a_o;
    logic [23:0] addr_b_o;
    logic        cycle_word_o;
    logic        irq_o;
    logic        run;
    logic [3:0]  gap;
    logic [31:0] rd;
    logic        err;
    int          fails;
    int          n_tests;

    dma_channel_status_reload i_dut (
        .ref_clk_i(ref_clk_i), .resetn_i(resetn_i), .psel_i(psel_i),
        .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
        .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o),
        .pslverr_o(pslverr_o), .beat_i(beat_i),
        .channel_active_o(channel_active_o), .addr_a_o(addr_a_o),
        .addr_b_o(addr_b_o), .cycle_word_o(cycle_word_o), .irq_o(irq_o));

    mover_model i_mover (
        .ref_clk_i(ref_clk_i), .resetn_i(resetn_i),
        .active_i(channel_active_o), .run_i(run), .gap_i(gap),
        .beat_o(beat_i));

    // Clock of 100 ns period.
    initial begin
        ref_clk_i = 1'b0;
        forever #50 ref_clk_i = ~ref_clk_i;
    end

    // Prints the counts and the verdict, then ends the run.
    task automatic complete_run();
        $display("Comparisons %0d, mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // One APB transfer: setup, access until pready, then one idle edge.
    task automatic xfer(input logic wr, input logic [11:0] a,
                        input logic [31:0] wd);
        int n;
        psel_i    <= 1'b1;
        penable_i <= 1'b0;
        pwrite_i  <= wr;
        paddr_i   <= a;
        pwdata_i  <= wd;
        @(posedge ref_clk_i);
        penable_i <= 1'b1;
        n = 0;
        do begin
            @(posedge ref_clk_i);
            n++;
        end while (pready_o !== 1'b1 && n < 20);
        rd  = prdata_o;
        err = pslverr_o;
        if (n >= 20) begin
            fails++;
            complete_run();
        end
        psel_i    <= 1'b0;
        penable_i <= 1'b0;
        @(posedge ref_clk_i);
    endtask

    task automatic wr32(input logic [11:0] a, input logic [31:0] d);
        xfer(1'b1, a, d);
    endtask

    task automatic rd_chk(input logic [11:0] a, input logic [31:0] e);
        xfer(1'b0, a, 32'h0);
        `CHECK("read data", e, rd)
    endtask

    // Waits, under a bound, until the channel reports inactive.
    task automatic wait_idle();
        int n;
        repeat (2) @(posedge ref_clk_i);
        n = 0;
        while (channel_active_o !== 1'b0 && n < 300) begin
            @(posedge ref_clk_i);
            n++;
        end
        if (n >= 300) begin
            fails++;
            complete_run();
        end
    endtask

    // Main sequence of register and transfer scenarios.
    initial begin
        int n;
        fails = 0;
        n_tests = 0;
        resetn_i = 1'b0;
        psel_i = 1'b0;
        penable_i = 1'b0;
        pwrite_i = 1'b0;
        paddr_i = 12'h000;
        pwdata_i = 32'h0;
        run = 1'b1;
        gap = 4'h3;
        repeat (5) @(posedge ref_clk_i);
        resetn_i <= 1'b1;
        @(posedge ref_clk_i);
        rd_chk(`OFS_STATUS, 32'h0);
        rd_chk(`OFS_CONTROL, `CONTROL_RESET);
        rd_chk(12'h040, 32'h0);
        `CHECK("unmapped error", 1'b1, err)
        // Double-buffer block of three beats with no next parameters.
        run <= 1'b0;
        wr32(`OFS_CONTROL, 32'h0000_0205);
        wr32(`OFS_CUR_ADDR_A, 32'h0000_0100);
        wr32(`OFS_CUR_COUNT, 32'h0000_0003);
        rd_chk(`OFS_STATUS, 32'h4);
        rd_chk(`OFS_CUR_COUNT, 32'h3);
        run <= 1'b1;
        wait_idle();
        rd_chk(`OFS_STATUS, 32'h3);
        `CHECK("addr a", 24'h000103, addr_a_o)
        rd_chk(`OFS_IRQ_STATUS, 32'h3);
        `CHECK("irq masked", 1'b0, irq_o)
        wr32(`OFS_IRQ_MASK, 32'h1);
        @(posedge ref_clk_i);
        `CHECK("irq raised", 1'b1, irq_o)
        wr32(`OFS_IRQ_STATUS, 32'h3);
        @(posedge ref_clk_i);
        `CHECK("irq cleared", 1'b0, irq_o)
        // Write-one-to-clear acts per flag; the active bit ignores writes.
        wr32(`OFS_STATUS, 32'h1);
        rd_chk(`OFS_STATUS, 32'h2);
        wr32(`OFS_STATUS, 32'hfc);
        rd_chk(`OFS_STATUS, 32'h2);
        wr32(`OFS_STATUS, 32'h2);
        // Reload from next parameters, then overrun on the second end.
        gap <= 4'h1;
        wr32(`OFS_RLD_ADDR_A, 32'h0000_0200);
        wr32(`OFS_RLD_COUNT, 32'h0000_0002);
        rd_chk(`OFS_STATUS, 32'h8);
        wr32(`OFS_CUR_ADDR_A, 32'h0000_0100);
        wr32(`OFS_CUR_COUNT, 32'h0000_0001);
        wait_idle();
        rd_chk(`OFS_STATUS, 32'h3);
        rd_chk(`OFS_CUR_ADDR_A, 32'h0000_0202);
        // Auto-initialize in word cycles with the count flag still set.
        wr32(`OFS_STATUS, 32'h2);
        wr32(`OFS_CONTROL, 32'h0000_0e17);
        wr32(`OFS_RLD_COUNT, 32'h0000_0002);
        wr32(`OFS_CUR_ADDR_A, 32'h0000_0400);
        wr32(`OFS_CUR_COUNT, 32'h0000_0002);
        `CHECK("word cycles", 1'b1, cycle_word_o)
        n = 0;
        do begin
            xfer(1'b0, `OFS_STATUS, 32'h0);
            n++;
        end while (rd[1] !== 1'b1 && n < 30);
        `CHECK("auto overrun", 1'b1, rd[1])
        // Only the enable bit changes while the channel runs.
        wr32(`OFS_CONTROL, 32'h0000_0e16);
        wait_idle();
        wr32(`OFS_CUR_COUNT, 32'h0);
        // Single buffer: overrun stays as software left it.
        wr32(`OFS_CONTROL, 32'h0000_0201);
        wr32(`OFS_STATUS, 32'hf);
        wr32(`OFS_CUR_ADDR_A, 32'h0000_0500);
        wr32(`OFS_CUR_COUNT, 32'h0000_0002);
        wait_idle();
        rd_chk(`OFS_STATUS, 32'h1);
        `CHECK("single addr", 24'h000502, addr_a_o)
        // Two-address double buffer: both addresses reload, B steps by two.
        wr32(`OFS_CONTROL, 32'h0000_320d);
        wr32(`OFS_RLD_ADDR_A, 32'h0000_0600);
        wr32(`OFS_RLD_ADDR_B, 32'h0000_0900);
        wr32(`OFS_RLD_COUNT, 32'h0000_0001);
        wr32(`OFS_CUR_ADDR_A, 32'h0000_0300);
        wr32(`OFS_CUR_ADDR_B, 32'h0000_0800);
        wr32(`OFS_CUR_COUNT, 32'h0000_0001);
        wait_idle();
        rd_chk(`OFS_STATUS, 32'h3);
        rd_chk(`OFS_CUR_ADDR_B, 32'h0000_0902);
        `CHECK("addr b", 24'h000902, addr_b_o)
        `CHECK("two addr a", 24'h000601, addr_a_o)
        // A reset with the channel idle clears every flag set above.
        resetn_i <= 1'b0;
        repeat (2) @(posedge ref_clk_i);
        resetn_i <= 1'b1;
        @(posedge ref_clk_i);
        rd_chk(`OFS_STATUS, 32'h0);
        complete_run();
    end
endmodule
`default_nettype wire
